// ==== rtl/hvs_ctrl.sv ====
// top of the high-voltage switch serial / parallel control front end
// Summary of operation
// R1: mode low selects 16-bit serial target; high makes pins parallel controls
// R2: host keeps the serial clock at or below 33 MHz
// R3: frame select falling presents the shift register msb on sdo
// R4: sdi is sampled on each rising sck edge inside a frame
// R5: host keeps sck idle while frame select is high
// R6: sdo advances one bit on each falling sck edge
// R7: shift-through: previous word comes out while the new one enters
// R8: frame select rising commits the word only when its write bit is set
// R9: frames are 16 bits msb first: write bit, 7 control, 8 outputs
// R10: output-state register bit n drives output n, updated on written frames
// R11: in serial mode setting pins are ignored, control register used
// R12: reset clears output-state and control registers
// R13: fault flag bit 6 sets on a vdd fault, or an hv fault while the comparator is on, clears only by writing 0
// R14: control bit 5 sleeps the analog part, forced low in parallel mode
// R15: control bit 4 high disables fault shutdown, low enables it
// R16: control bit 3 high turns off the high-voltage under-voltage comparator
// R17: control bit 2 picks 90 V when high, 80 V when low
// R18: control bit 1 enables the charge pump
// R19: control bit 0 picks the 60 uA drive current when high, else 30 uA
// R20: control bit 7 is the write bit; zero makes a read-only frame
// R21: host pulses frame select once after entering serial mode
// R22: parallel mode maps controls to outputs, mirrored or coded by table
// R23: host holds mirror select high in serial mode
// R24: enabled shutdown forces outputs low, pump off, until pump toggles low-high
// R25: open-drain fault pin follows the fault unlatched
// R26: serial bit counter held in reset while frame select is high
`timescale 1ns/10ps
module hvs_ctrl (
  input  wire logic       I_CLK,
  input  wire logic       I_RESETN,
  input  wire logic       I_SCK,
  input  wire logic       I_SDI,
  input  wire logic       I_SDO,
  input  wire logic       I_FRAME_SELECT_N,
  input  wire logic       I_MODE,
  input  wire logic       I_MIRROR_SELECT,
  input  wire logic       I_DRIVE_CURRENT_PIN,
  input  wire logic       I_HV_LEVEL_SELECT_PIN,
  input  wire logic       I_PUMP_ENABLE_PIN,
  input  wire logic       I_FAULT_BEHAVIOUR_PIN,
  input  wire logic       I_VDD_UV_FAULT,
  input  wire logic       I_HV_UV_FAULT,
  output logic [7:0]      O_HIGH_VOLTAGE_OUTPUT,
  output logic            O_SDO,
  output logic            O_SDO_OE,
  output logic            O_FAULT_OPEN_DRAIN_N,
  output logic            O_FAULT_OPEN_DRAIN_N_OE,
  output logic            O_DRIVE_CURRENT_SELECT,
  output logic            O_HV_LEVEL_SELECT,
  output logic            O_HV_UV_COMPARATOR_OFF,
  output logic            O_PUMP_ENABLE,
  output logic            O_SLEEP,
  output logic            O_LATCHED_FAULT_FLAG
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int SYNC_W = 13;

  logic [SYNC_W-1:0]                 sync_in;
  logic [SYNC_W-1:0]                 sync_out;
  logic [hvs_pkg::FRAME_BITS-1:0]    link_word;
  logic                              link_toggle;
  logic                              mode_s;
  logic                              frame_n_s;
  logic                              sck_s;
  logic                              sdi_s;
  logic                              sdo_in_s;
  logic                              mirror_s;
  logic                              curr_pin_s;
  logic                              level_pin_s;
  logic                              pump_pin_s;
  logic                              fbeh_pin_s;
  logic                              vdd_fault_s;
  logic                              hv_fault_s;
  logic                              toggle_s;
  logic                              toggle_d;
  logic                              word_arrived;
  logic                              pending;
  logic [hvs_pkg::FRAME_BITS-1:0]    rx_hold;
  logic                              serial;
  logic                              commit;
  logic                              write_frame;
  logic [hvs_pkg::STATE_W-1:0]       output_switch_state;
  logic [hvs_pkg::CTRL_W-1:0]        driver_control_status;
  logic                              latched_fault_flag;
  logic                              fault_shutdown_disable;
  logic                              hv_uv_comparator_off;
  logic                              hv_level_select_bit;
  logic                              pump_enable_bit;
  logic                              drive_current_select_bit;
  logic                              sleep_eff;
  logic                              fault_any;
  logic [3:0]                        code;
  logic [hvs_pkg::STATE_W-1:0]       next_par_out;
  hvs_pkg::hvs_fault_state_t         fault_state;
  hvs_pkg::hvs_fault_state_t         next_fault_state;

  // ----------------------------------------------------------------
  // serial link on its own clock
  // ----------------------------------------------------------------
  hvs_link u_link (
    .i_sck            (I_SCK),
    .i_resetn         (I_RESETN),
    .i_frame_select_n (I_FRAME_SELECT_N),
    .i_sdi            (I_SDI),
    .o_sdo            (O_SDO),
    .o_rx_word        (link_word),
    .o_rx_toggle      (link_toggle)
  );

  // ----------------------------------------------------------------
  // pin and link-event synchronisers
  // ----------------------------------------------------------------
  assign sync_in = {I_MODE, I_FRAME_SELECT_N, I_SCK, I_SDI, I_SDO,
                    I_MIRROR_SELECT, I_DRIVE_CURRENT_PIN,
                    I_HV_LEVEL_SELECT_PIN, I_PUMP_ENABLE_PIN,
                    I_FAULT_BEHAVIOUR_PIN, I_VDD_UV_FAULT, I_HV_UV_FAULT,
                    link_toggle};

  hvs_sync #(
    .W (SYNC_W)
  ) u_sync (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_d      (sync_in),
    .o_q      (sync_out)
  );

  assign mode_s      = sync_out[12];
  assign frame_n_s   = sync_out[11];
  assign sck_s       = sync_out[10];
  assign sdi_s       = sync_out[9];
  assign sdo_in_s    = sync_out[8];
  assign mirror_s    = sync_out[7];
  assign curr_pin_s  = sync_out[6];
  assign level_pin_s = sync_out[5];
  assign pump_pin_s  = sync_out[4];
  assign fbeh_pin_s  = sync_out[3];
  assign vdd_fault_s = sync_out[2];
  assign hv_fault_s  = sync_out[1];
  assign toggle_s    = sync_out[0];

  assign serial = ~mode_s; // R1

  // ----------------------------------------------------------------
  // received word capture
  // ----------------------------------------------------------------
  assign word_arrived = toggle_s ^ toggle_d;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      toggle_d <= 1'b0;
    end else begin
      toggle_d <= toggle_s;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rx_hold <= hvs_pkg::WORD_RST;
    end else if (word_arrived) begin
      rx_hold <= link_word; // R7
    end
  end

  // commit once the frame has ended
  assign commit      = serial & pending & frame_n_s; // R8
  assign write_frame = commit & rx_hold[hvs_pkg::WORD_WE_POS]; // R20

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pending <= 1'b0;
    end else if (word_arrived && serial) begin
      pending <= 1'b1;
    end else if (commit || !serial) begin
      pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // output-state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      output_switch_state <= hvs_pkg::STATE_RST; // R12
    end else if (write_frame) begin
      output_switch_state <= rx_hold[hvs_pkg::STATE_W-1:0]; // R10 R9
    end
  end

  // ----------------------------------------------------------------
  // control register, writable bits
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      driver_control_status <= hvs_pkg::CTRL_RST; // R12
    end else if (write_frame) begin
      driver_control_status <= rx_hold[hvs_pkg::CTRL_LSB +: hvs_pkg::CTRL_W]; // R9
    end
  end

  // ----------------------------------------------------------------
  // latched fault status, set beats clear
  // ----------------------------------------------------------------
  assign fault_any = vdd_fault_s | (hv_fault_s & ~hv_uv_comparator_off); // R16

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      latched_fault_flag <= 1'b0; // R12
    end else if (fault_any) begin
      latched_fault_flag <= 1'b1; // R13
    end else if (write_frame
                 && !rx_hold[hvs_pkg::CTRL_LSB + hvs_pkg::CTL_FAULT]) begin
      latched_fault_flag <= 1'b0; // R13
    end
  end

  // ----------------------------------------------------------------
  // effective settings, register or pins by mode
  // ----------------------------------------------------------------
  always_comb begin
    if (serial) begin
      fault_shutdown_disable   = driver_control_status[hvs_pkg::CTL_FDIS]; // R11 R15
      hv_uv_comparator_off     = driver_control_status[hvs_pkg::CTL_COMP]; // R16
      hv_level_select_bit      = driver_control_status[hvs_pkg::CTL_LEVEL]; // R17
      pump_enable_bit          = driver_control_status[hvs_pkg::CTL_PUMP]; // R18
      drive_current_select_bit = driver_control_status[hvs_pkg::CTL_CURR]; // R19
      sleep_eff                = driver_control_status[hvs_pkg::CTL_SLEEP]; // R14
    end else begin
      fault_shutdown_disable   = fbeh_pin_s;
      hv_uv_comparator_off     = ~pump_pin_s;
      hv_level_select_bit      = level_pin_s;
      pump_enable_bit          = pump_pin_s;
      drive_current_select_bit = curr_pin_s;
      sleep_eff                = 1'b0; // R14
    end
  end

  // ----------------------------------------------------------------
  // parallel decoder
  // ----------------------------------------------------------------
  assign code = {frame_n_s, sdo_in_s, sdi_s, sck_s};

  always_comb begin
    next_par_out = hvs_pkg::ALL_OFF;
    if (!mirror_s) begin
      next_par_out = {code[0], code[1], code[2], code[3],
                      code[3], code[2], code[1], code[0]}; // R22
    end else begin
      case (code)
        4'h0, 4'hF: next_par_out = hvs_pkg::ALL_OFF; // R22
        4'h9:       next_par_out = hvs_pkg::PAT_9;
        4'hA:       next_par_out = hvs_pkg::PAT_10;
        4'hB:       next_par_out = hvs_pkg::PAT_11;
        4'hC:       next_par_out = hvs_pkg::PAT_12;
        4'hD:       next_par_out = hvs_pkg::PAT_13;
        4'hE:       next_par_out = hvs_pkg::PAT_14;
        default:    next_par_out = 8'(hvs_pkg::ONE_HOT << (code - 4'h1)); // R22
      endcase
    end
  end

  // ----------------------------------------------------------------
  // fault shutdown state machine
  // ----------------------------------------------------------------
  always_comb begin
    case (fault_state)
      hvs_pkg::FS_RUN: begin
        if (fault_any && !fault_shutdown_disable) begin
          next_fault_state = hvs_pkg::FS_TRIP; // R24
        end else begin
          next_fault_state = hvs_pkg::FS_RUN;
        end
      end
      hvs_pkg::FS_TRIP: begin
        if (!pump_enable_bit) begin
          next_fault_state = hvs_pkg::FS_ARMED; // R24
        end else begin
          next_fault_state = hvs_pkg::FS_TRIP;
        end
      end
      hvs_pkg::FS_ARMED: begin
        if (fault_any && !fault_shutdown_disable) begin
          next_fault_state = hvs_pkg::FS_TRIP;
        end else if (pump_enable_bit) begin
          next_fault_state = hvs_pkg::FS_RUN; // R24
        end else begin
          next_fault_state = hvs_pkg::FS_ARMED;
        end
      end
      default: next_fault_state = hvs_pkg::FS_RUN;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fault_state <= hvs_pkg::FS_RUN;
    end else begin
      fault_state <= next_fault_state;
    end
  end

  // ----------------------------------------------------------------
  // high-voltage output drive
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_HIGH_VOLTAGE_OUTPUT <= hvs_pkg::ALL_OFF;
    end else if (next_fault_state != hvs_pkg::FS_RUN) begin
      O_HIGH_VOLTAGE_OUTPUT <= hvs_pkg::ALL_OFF; // R24
    end else if (serial) begin
      O_HIGH_VOLTAGE_OUTPUT <= output_switch_state; // R10
    end else begin
      O_HIGH_VOLTAGE_OUTPUT <= next_par_out; // R22
    end
  end

  // ----------------------------------------------------------------
  // analog control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_DRIVE_CURRENT_SELECT <= 1'b0;
      O_HV_LEVEL_SELECT      <= 1'b0;
      O_HV_UV_COMPARATOR_OFF <= 1'b0;
      O_PUMP_ENABLE          <= 1'b0;
      O_SLEEP                <= 1'b0;
      O_LATCHED_FAULT_FLAG   <= 1'b0;
    end else begin
      O_DRIVE_CURRENT_SELECT <= drive_current_select_bit; // R19
      O_HV_LEVEL_SELECT      <= hv_level_select_bit; // R17
      O_HV_UV_COMPARATOR_OFF <= hv_uv_comparator_off; // R16
      O_PUMP_ENABLE          <= pump_enable_bit
                                & (next_fault_state == hvs_pkg::FS_RUN); // R18 R24
      O_SLEEP                <= sleep_eff; // R14
      O_LATCHED_FAULT_FLAG   <= latched_fault_flag;
    end
  end

  // ----------------------------------------------------------------
  // open-drain fault pin and serial data enable
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_FAULT_OPEN_DRAIN_N    <= 1'b1;
      O_FAULT_OPEN_DRAIN_N_OE <= 1'b0;
    end else begin
      O_FAULT_OPEN_DRAIN_N    <= 1'b0;
      O_FAULT_OPEN_DRAIN_N_OE <= fault_any; // R25
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SDO_OE <= 1'b0;
    end else begin
      O_SDO_OE <= serial; // R1
    end
  end
endmodule : hvs_ctrl

// ==== rtl/hvs_pkg.sv ====
// constants shared by the high-voltage switch control front end
package hvs_pkg;
  // ----------------------------------------------------------------
  // serial frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS  = 16;
  localparam int CNT_W       = 4;
  localparam int WORD_WE_POS = 15;
  localparam int CTRL_LSB    = 8;
  localparam int CTRL_W      = 8;
  localparam int STATE_W     = 8;
  localparam logic [CNT_W-1:0] LAST_BIT = 4'hF;
  // ----------------------------------------------------------------
  // control byte fields
  // ----------------------------------------------------------------
  localparam int CTL_WE    = 7;
  localparam int CTL_FAULT = 6;
  localparam int CTL_SLEEP = 5;
  localparam int CTL_FDIS  = 4;
  localparam int CTL_COMP  = 3;
  localparam int CTL_LEVEL = 2;
  localparam int CTL_PUMP  = 1;
  localparam int CTL_CURR  = 0;
  // ----------------------------------------------------------------
  // reset values and link timing
  // ----------------------------------------------------------------
  localparam logic [STATE_W-1:0]   STATE_RST = 8'h00;
  localparam logic [CTRL_W-1:0]    CTRL_RST  = 8'h00;
  localparam logic [FRAME_BITS-1:0] WORD_RST = 16'h0000;
  localparam int SCK_MAX_MHZ = 33;
  // ----------------------------------------------------------------
  // table-coded patterns, used when mirror select is high
  // ----------------------------------------------------------------
  localparam logic [STATE_W-1:0] PAT_9  = 8'hA9;
  localparam logic [STATE_W-1:0] PAT_10 = 8'hA6;
  localparam logic [STATE_W-1:0] PAT_11 = 8'h9A;
  localparam logic [STATE_W-1:0] PAT_12 = 8'h6A;
  localparam logic [STATE_W-1:0] PAT_13 = 8'hAA;
  localparam logic [STATE_W-1:0] PAT_14 = 8'h55;
  localparam logic [STATE_W-1:0] ALL_OFF = 8'h00;
  localparam logic [STATE_W-1:0] ONE_HOT = 8'h01;
  // ----------------------------------------------------------------
  // fault shutdown states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FS_RUN   = 3'b001,
    FS_TRIP  = 3'b010,
    FS_ARMED = 3'b100
  } hvs_fault_state_t;
endpackage : hvs_pkg

// ==== rtl/hvs_sync.sv ====
// two-stage synchroniser for a group of level inputs
`timescale 1ns/10ps
module hvs_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // two flops, first one read only by the second
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta <= '0;
      o_q  <= '0;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : hvs_sync

// ==== rtl/hvs_link.sv ====
// serial shift-through link running on the serial clock
`timescale 1ns/10ps
module hvs_link (
  input  wire logic        i_sck,
  input  wire logic        i_resetn,
  input  wire logic        i_frame_select_n,
  input  wire logic        i_sdi,
  output logic             o_sdo,
  output logic [15:0]      o_rx_word,
  output logic             o_rx_toggle
);
  logic [hvs_pkg::FRAME_BITS-1:0] shreg;
  logic [hvs_pkg::CNT_W-1:0]      cnt;
  logic                           sdi_cap;
  logic                           link_clr;

  assign link_clr = ~i_resetn | i_frame_select_n;
  assign o_sdo    = shreg[hvs_pkg::FRAME_BITS-1]; // R3

  // ----------------------------------------------------------------
  // input sampling on rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      sdi_cap <= 1'b0;
    end else if (!i_frame_select_n) begin
      sdi_cap <= i_sdi; // R4
    end
  end

  // ----------------------------------------------------------------
  // bit counter, cleared while deselected
  // ----------------------------------------------------------------
  always_ff @(negedge i_sck or posedge link_clr) begin
    if (link_clr) begin
      cnt <= '0; // R26
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // shift on falling edge, msb drives sdo
  // ----------------------------------------------------------------
  always_ff @(negedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      shreg <= hvs_pkg::WORD_RST;
    end else if (!i_frame_select_n) begin
      shreg <= {shreg[hvs_pkg::FRAME_BITS-2:0], sdi_cap}; // R6 R7
    end
  end

  // ----------------------------------------------------------------
  // whole word handed over with a toggle
  // ----------------------------------------------------------------
  always_ff @(negedge i_sck or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rx_word   <= hvs_pkg::WORD_RST;
      o_rx_toggle <= 1'b0;
    end else if (!i_frame_select_n && cnt == hvs_pkg::LAST_BIT) begin
      o_rx_word   <= {shreg[hvs_pkg::FRAME_BITS-2:0], sdi_cap}; // R9
      o_rx_toggle <= ~o_rx_toggle;
    end
  end
endmodule : hvs_link

// ==== testbench/hvs_ctrl_sva.sv ====
// assertion checker for the switch control front end
`timescale 1ns/10ps
module hvs_ctrl_sva (
  input wire logic       I_CLK,
  input wire logic       I_RESETN,
  input wire logic       I_SCK,
  input wire logic       I_SDI,
  input wire logic       I_SDO,
  input wire logic       I_FRAME_SELECT_N,
  input wire logic       I_MODE,
  input wire logic       I_MIRROR_SELECT,
  input wire logic       I_FAULT_BEHAVIOUR_PIN,
  input wire logic       I_VDD_UV_FAULT,
  input wire logic       I_HV_UV_FAULT,
  input wire logic [7:0] O_HIGH_VOLTAGE_OUTPUT,
  input wire logic       O_SDO_OE,
  input wire logic       O_FAULT_OPEN_DRAIN_N_OE,
  input wire logic       O_PUMP_ENABLE,
  input wire logic       O_SLEEP,
  input wire logic       O_LATCHED_FAULT_FLAG
);
  // --------
  // helpers
  // --------
  wire       nf  = !I_VDD_UV_FAULT && !I_HV_UV_FAULT;
  wire [7:0] mir = {I_SCK, I_SDI, I_SDO, I_FRAME_SELECT_N,
                    I_FRAME_SELECT_N, I_SDO, I_SDI, I_SCK};
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  property p_oe_ser; (!I_MODE)[*6] |-> O_SDO_OE; endproperty
  a_oe_ser: assert property (p_oe_ser) else $error("sdo enable low");
  property p_oe_par; I_MODE[*6] |-> !O_SDO_OE; endproperty
  a_oe_par: assert property (p_oe_par) else $error("sdo enable high");
  property p_sleep; I_MODE[*5] |-> !O_SLEEP; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep in parallel");
  property p_set; I_VDD_UV_FAULT[*5]
    |-> O_LATCHED_FAULT_FLAG && O_FAULT_OPEN_DRAIN_N_OE; endproperty
  a_set: assert property (p_set) else $error("fault not flagged");
  property p_rel; nf[*6] |-> !O_FAULT_OPEN_DRAIN_N_OE; endproperty
  a_rel: assert property (p_rel) else $error("fault pin stuck");
  property p_shut; (I_MODE && !I_FAULT_BEHAVIOUR_PIN && I_VDD_UV_FAULT)[*5]
    |-> !O_PUMP_ENABLE && O_HIGH_VOLTAGE_OUTPUT == 8'h00; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_hold; (!I_MODE && !I_FRAME_SELECT_N && nf)[*8]
    |-> $stable(O_HIGH_VOLTAGE_OUTPUT); endproperty
  a_hold: assert property (p_hold) else $error("outputs moved in frame");
  property p_mir; (I_MODE && !I_MIRROR_SELECT && nf && O_PUMP_ENABLE && $stable(mir))[*5]
    |-> O_HIGH_VOLTAGE_OUTPUT == mir; endproperty
  a_mir: assert property (p_mir) else $error("mirror map wrong");
endmodule : hvs_ctrl_sva
bind hvs_ctrl hvs_ctrl_sva u_hvs_ctrl_sva (.I_CLK(I_CLK), .I_RESETN(I_RESETN),
  .I_SCK(I_SCK), .I_SDI(I_SDI), .I_SDO(I_SDO), .I_FRAME_SELECT_N(I_FRAME_SELECT_N),
  .I_MODE(I_MODE), .I_MIRROR_SELECT(I_MIRROR_SELECT),
  .I_FAULT_BEHAVIOUR_PIN(I_FAULT_BEHAVIOUR_PIN), .I_VDD_UV_FAULT(I_VDD_UV_FAULT),
  .I_HV_UV_FAULT(I_HV_UV_FAULT), .O_HIGH_VOLTAGE_OUTPUT(O_HIGH_VOLTAGE_OUTPUT),
  .O_SDO_OE(O_SDO_OE), .O_FAULT_OPEN_DRAIN_N_OE(O_FAULT_OPEN_DRAIN_N_OE),
  .O_PUMP_ENABLE(O_PUMP_ENABLE), .O_SLEEP(O_SLEEP),
  .O_LATCHED_FAULT_FLAG(O_LATCHED_FAULT_FLAG));

// ==== testbench/hvs_host.sv ====
// behavioural serial host for the switch control front end
`timescale 1ns/10ps
module hvs_host (
  input  wire logic i_sdo,
  output logic      o_sck,
  output logic      o_sdi,
  output logic      o_frame_select_n
);
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
    o_frame_select_n = 1'b1;
  end
  // lone select pulse to restart the link
  task pulse;
    #3 o_frame_select_n = 1'b0;
    #40 o_frame_select_n = 1'b1;
    #100;
  endtask : pulse
  // one frame, 64 ns bit time, msb first
  task xfer(input logic [15:0] w, output logic [15:0] r);
    #3 o_frame_select_n = 1'b0;
    #20;
    for (int i = 15; i >= 0; i--) begin
      o_sdi = w[i];
      #16 r[i] = i_sdo;
      o_sck = 1'b1;
      #32 o_sck = 1'b0;
      #16;
    end
    o_sdi = ~o_sdi;
    #40 o_frame_select_n = 1'b1;
    #100;
  endtask : xfer
endmodule : hvs_host

// ==== testbench/test_hvs_ctrl.sv ====
// self-checking bench for the switch control front end
`timescale 1ns/10ps
module test_hvs_ctrl;
  logic        I_CLK = 1'b0;
  logic        I_RESETN = 1'b0;
  logic        I_MODE = 1'b0;
  logic        I_MIRROR_SELECT = 1'b1;
  logic [3:0]  ctl = 4'h0;
  logic [3:0]  pin = 4'h0;
  logic [1:0]  flt = 2'b00;
  logic        h_sck, h_sdi, h_fsn, I_SCK, I_SDI, I_SDO, I_FRAME_SELECT_N;
  logic [7:0]  hv;
  logic        sdo, sdo_oe, fod, fod_oe, cur, lvl, cmp, pmp, slp, lat;
  logic [15:0] r;
  logic [7:0]  tbl [16] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
                            8'h80, 8'hA9, 8'hA6, 8'h9A, 8'h6A, 8'hAA, 8'h55, 8'h00};
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #4 I_CLK = ~I_CLK;
  assign I_SCK = I_MODE ? ctl[0] : h_sck;
  assign I_SDI = I_MODE ? ctl[1] : h_sdi;
  assign I_FRAME_SELECT_N = I_MODE ? ctl[3] : h_fsn;
  assign I_SDO = sdo_oe ? sdo : ctl[2];
  hvs_ctrl u_hvs_ctrl (.I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SCK(I_SCK), .I_SDI(I_SDI),
    .I_SDO(I_SDO), .I_FRAME_SELECT_N(I_FRAME_SELECT_N), .I_MODE(I_MODE),
    .I_MIRROR_SELECT(I_MIRROR_SELECT), .I_DRIVE_CURRENT_PIN(pin[0]),
    .I_HV_LEVEL_SELECT_PIN(pin[1]), .I_PUMP_ENABLE_PIN(pin[2]),
    .I_FAULT_BEHAVIOUR_PIN(pin[3]), .I_VDD_UV_FAULT(flt[0]), .I_HV_UV_FAULT(flt[1]),
    .O_HIGH_VOLTAGE_OUTPUT(hv), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .O_FAULT_OPEN_DRAIN_N(fod),
    .O_FAULT_OPEN_DRAIN_N_OE(fod_oe), .O_DRIVE_CURRENT_SELECT(cur), .O_HV_LEVEL_SELECT(lvl),
    .O_HV_UV_COMPARATOR_OFF(cmp), .O_PUMP_ENABLE(pmp), .O_SLEEP(slp),
    .O_LATCHED_FAULT_FLAG(lat));
  hvs_host u_hvs_host (.i_sdo(sdo), .o_sck(h_sck), .o_sdi(h_sdi), .o_frame_select_n(h_fsn));
  // --------
  // helpers
  // --------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task wt(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask : wt
  task xf(input logic [15:0] w, input logic [15:0] exp);
    u_hvs_host.xfer(w, r);
    chk(r, exp);
  endtask : xf
  // --------
  // scenarios
  // --------
  task t_serial;
    chk(16'({hv, cur, lvl, cmp, pmp, slp, lat, fod_oe, fod}), 16'h0000);
    u_hvs_host.pulse;
    xf(16'h8FA5, 16'h0000);
    chk(hv, 16'h00A5);
    chk(16'({slp, cmp, lvl, pmp, cur}), 16'h000F);
    xf(16'h7F3C, 16'h8FA5);
    chk(hv, 16'h00A5);
    xf(16'hA05A, 16'h7F3C);
    chk(16'({hv, slp, cmp, lvl, pmp, cur}), 16'h0B50);
  endtask : t_serial
  task t_par;
    @(posedge I_CLK);
    I_MODE <= 1'b1;
    pin <= 4'b0111;
    wt(6);
    chk(16'({sdo_oe, slp, lvl, cur}), 16'h0003);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge I_CLK);
        I_MIRROR_SELECT <= m[0];
        ctl <= c[3:0];
        wt(5);
        chk(hv, 16'(m ? tbl[c] : {c[0], c[1], c[2], c[3], c[3:0]}));
      end
    end
  endtask : t_par
  task t_fault;
    @(posedge I_CLK);
    I_MIRROR_SELECT <= 1'b0;
    ctl <= 4'h1;
    flt <= 2'b01;
    wt(8);
    chk(16'({hv, pmp, lat, fod_oe}), 16'h0003);
    @(posedge I_CLK);
    flt <= 2'b00;
    wt(8);
    chk(16'({hv, lat, fod_oe}), 16'h0002);
    @(posedge I_CLK);
    pin[2] <= 1'b0;
    wt(8);
    @(posedge I_CLK);
    pin[2] <= 1'b1;
    wt(8);
    chk(hv, 16'h0081);
  endtask : t_fault
  task t_sflt;
    @(posedge I_CLK);
    I_MODE <= 1'b0;
    I_MIRROR_SELECT <= 1'b1;
    wt(10);
    u_hvs_host.pulse;
    u_hvs_host.xfer(16'h9AFF, r);
    chk(lat, 16'h0000);
    @(posedge I_CLK);
    flt <= 2'b10;
    wt(8);
    chk(16'({lat, fod_oe}), 16'h0000);
    @(posedge I_CLK);
    flt <= 2'b01;
    wt(8);
    chk(16'({hv, lat, fod_oe}), 16'h03FF);
    @(posedge I_CLK);
    flt <= 2'b00;
    wt(8);
    xf(16'hC2FF, 16'h9AFF);
    chk(lat, 16'h0001);
    xf(16'h82FF, 16'hC2FF);
    chk(lat, 16'h0000);
  endtask : t_sflt
  initial begin
    repeat (4) @(posedge I_CLK);
    I_RESETN <= 1'b1;
    wt(4);
    t_serial;
    t_par;
    t_fault;
    t_sflt;
    conclude;
  end
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude;
    end
  end
endmodule : test_hvs_ctrl
